// ### bidir_io_port_bank_tb_top.sv
// Purpose: Directed test of the I/O port bank
// Assumes: Default parameters, pins read two clocks late
// Notes: Inputs move at falling edges only
`timescale 1ns/100ps
`default_nettype none
module bidir_io_port_bank_tb_top
    import gpio_bank_pkg::*;
;
    logic clock, rst, wr_en, rd_en, core_asleep, rvalid, wake_req;
    logic [2:0] addr;
    logic [7:0] wdata, func_gpio, func_open_drain, ext_en, ext_lvl;
    logic [7:0] rdata, pin_in, pin_out, pin_oe, pullup_on;
    logic [15:0] pin_supply, pin_drive;
    int bad_count, num_checks, cycles;
    gpio_port_bank u_dut (.clock, .rst, .addr, .wr_en, .rd_en, .wdata, .rdata, .rvalid,
        .func_gpio, .func_open_drain, .core_asleep, .pin_in, .pin_out, .pin_oe,
        .pullup_on, .pin_supply, .pin_drive, .wake_req);
    ext_pin_model u_ext (.clock, .pin_out, .pin_oe, .pullup_on, .ext_en, .ext_lvl,
        .pin_lvl(pin_in));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clock);
        wr_en = 1'b0;
        // Strobe stays low a full cycle so a following write raises it later
        @(negedge clock);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        addr = a;
        rd_en = 1'b1;
        @(negedge clock);
        rd_en = 1'b0;
        chk(rvalid, 1'b1);
        @(negedge clock);
        chk(rdata, exp);
    endtask
    function automatic logic [1:0] sup(input logic [1:0] k);
        return (k < 2) ? 2'h0 : k - 2'h1;
    endfunction
    task automatic wake_try(input logic [7:0] fall_mask, input logic [15:0] exp);
        int n;
        n = 0;
        ext_lvl = 8'hFF;
        repeat (4) @(negedge clock);
        ext_lvl = ~fall_mask;
        repeat (8) begin
            @(negedge clock);
            n += wake_req;
        end
        chk(n[15:0], exp);
    endtask
    task automatic t_reset();
        chk(pin_oe, 8'h00);
        // Pin level needs two clocks through the synchroniser
        repeat (2) @(negedge clock);
        rd(REG_DATA, 8'hA5);
        rd(REG_DIR, 8'hFF);
        rd(REG_PULLUP, 8'h00);
        rd(REG_WAKEUP, 8'h00);
        rd(REG_PWR_SRC, 8'h00);
        rd(REG_DRIVE, 8'h00);
        rd(3'h7, 8'h00);
    endtask
    task automatic t_output();
        ext_en = 8'hF0;
        ext_lvl = 8'h5A;
        wr(REG_DATA, 8'h3C);
        wr(REG_DIR, 8'hF0);
        chk(pin_oe, 8'h0F);
        chk(pin_out & 8'h0F, 8'h0C);
        rd(REG_DATA, 8'h5C);
        ext_lvl = 8'hA5;
        repeat (3) @(negedge clock);
        rd(REG_DATA, 8'hAC);
        chk(pin_out, 8'h3C);
    endtask
    task automatic t_pullup();
        func_gpio = 8'h3E;
        func_open_drain = 8'h01;
        wr(REG_PULLUP, 8'hFF);
        chk(pullup_on, 8'h30 | 8'h01);
        wr(REG_PULLUP, 8'h00);
        chk(pullup_on, 8'h00);
        func_gpio = 8'hFF;
        func_open_drain = 8'h00;
        wr(REG_DIR, 8'hFF);
        ext_en = 8'hFF;
    endtask
    task automatic t_power();
        for (int c = 0; c < 4; c++) begin
            // Aux supply pin function taken as already enabled
            wr(REG_PWR_SRC, {4'hF, 2'(c), ~2'(c)});
            rd(REG_PWR_SRC, {4'h0, 2'(c), ~2'(c)});
            chk(pin_supply[15:14], sup(2'(c)));
            chk(pin_supply[1:0], sup(~2'(c)));
        end
        func_gpio = 8'h7F;
        @(negedge clock);
        chk(pin_supply[15:14], 2'h0);
        func_gpio = 8'h00;
        @(negedge clock);
        chk(pin_supply, 16'h0000);
        func_gpio = 8'hFF;
    endtask
    task automatic t_wake();
        wr(REG_WAKEUP, 8'h07);
        rd(REG_WAKEUP, 8'h07);
        core_asleep = 1'b1;
        wake_try(8'h01, 16'h1);
        func_gpio = 8'hFB;
        wake_try(8'h04, 16'h0);
        func_gpio = 8'hFF;
        wake_try(8'h08, 16'h0);
        core_asleep = 1'b0;
        wake_try(8'h02, 16'h0);
    endtask
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Whole run needs about 125 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        rst = 1'b1;
        {wr_en, rd_en, core_asleep, addr, wdata, func_open_drain} = '0;
        func_gpio = 8'hFF;
        ext_en = 8'hFF;
        ext_lvl = 8'hA5;
        repeat (16) @(negedge clock);
        rst = 1'b0;
        t_reset();
        t_output();
        t_pullup();
        t_power();
        wr(REG_DRIVE, 8'hE4);
        chk(pin_drive, 16'hFA50);
        rd(REG_DRIVE, 8'hE4);
        t_wake();
        wrap_up();
    end
endmodule
`default_nettype wire

// ### ext_pin_model.sv
// Purpose: Outside circuitry on the port pins
// Assumes: One source per pin, enabled by ext_en
// Notes: A floating pin without pull-up toggles
`timescale 1ns/100ps
`default_nettype none
module ext_pin_model (
    // Clock
    input wire logic clock,
    // Device side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    // Outside source
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_lvl,
    // Resolved level
    output logic [7:0] pin_lvl
);
    logic [7:0] last_q;
    always_ff @(posedge clock) begin
        last_q <= pin_lvl;
    end
    // Source level only changes at falling edges
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
        | (~pin_oe & ~ext_en & (pullup_on | ~last_q));
endmodule
`default_nettype wire

// ### gpio_bank_pkg.sv
// Purpose: Constants shared by the I/O port bank design.
// Assumes: One 8-pin port, byte-wide data-memory access.
// Notes: Register indices sit on the internal data-memory bus.
package gpio_bank_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;

    // Register indices
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_DIR = 3'h1;
    localparam logic [2:0] REG_PULLUP = 3'h2;
    localparam logic [2:0] REG_WAKEUP = 3'h3;
    localparam logic [2:0] REG_PWR_SRC = 3'h4;
    localparam logic [2:0] REG_DRIVE = 3'h5;

    // Reset values
    localparam logic [7:0] DATA_RST = 8'hFF;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] PULLUP_RST = 8'h00;
    localparam logic [7:0] WAKEUP_RST = 8'h00;
    localparam logic [3:0] PWR_SRC_RST = 4'h0;
    localparam logic [7:0] DRIVE_RST = 8'h00;

    // Power source register layout
    localparam int PWR_SRC_W = 4;
    localparam int PWR_UPPER_LSB = 2;
    localparam int PWR_LOWER_LSB = 0;
    localparam int FIELD_W = 2;

    // Power source codes as written by software
    localparam logic [1:0] PSEL_MAIN_A = 2'h0;
    localparam logic [1:0] PSEL_MAIN_B = 2'h1;
    localparam logic [1:0] PSEL_AUX = 2'h2;
    localparam logic [1:0] PSEL_REG3V3 = 2'h3;

    // Supply actually routed to a pin
    typedef enum logic [1:0] {
        SUPPLY_MAIN,
        SUPPLY_AUX,
        SUPPLY_REG3V3
    } supply_t;

    // Drive level codes
    localparam logic [1:0] DRIVE_MIN = 2'h0;
    localparam logic [1:0] DRIVE_MAX = 2'h3;
endpackage

// ### gpio_port_bank.sv
// Purpose: One bidirectional I/O port with direction, pull-up, wake-up,
//          power source and drive level control.
// Assumes: Core uses a byte-wide data-memory bus, read data one cycle later.
// Notes: Analog pull-up, supply and drive are control outputs only.
// Functional notes
// - Direction 1 makes pin input, read live level
// - Direction 0 drives latch value push-pull
// - Output pin reads back latch, not pin
// - Output latch holds until rewritten
// - Per-pin pull-up enable, reset clear
// - Pull-up only for digital input or open-drain
// - Falling edge on enabled pin wakes core
// - Per-pin wake-up enable, reset clear
// - Wake-up only as GPIO input while sleeping
// - Upper power field selects first group supply
// - Lower power field, same codes, reset zero
// - Supply choice only for digital pins, debug excepted
// - Two-bit drive fields, min to max, reset zero
// - Unimplemented bits ignore writes, read zero
// - Direction bits reset to input
`timescale 1ns/100ps
`default_nettype none
module gpio_port_bank
    import gpio_bank_pkg::*;
#(
    parameter int PINS = 8,
    parameter logic [7:0] IMPL_MASK = 8'hFF,
    parameter logic [7:0] WAKE_MASK = 8'hFF,
    parameter logic [7:0] UPPER_GROUP = 8'hF0,
    parameter logic [7:0] LOWER_GROUP = 8'h0F,
    parameter logic [7:0] DEBUG_MASK = 8'h00
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Data-memory access
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata,
    output logic rvalid,
    // Pin function and power state
    input wire logic [PINS-1:0] func_gpio,
    input wire logic [PINS-1:0] func_open_drain,
    input wire logic core_asleep,
    // Pins
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    // Analog controls
    output logic [PINS-1:0] pullup_on,
    output logic [2*PINS-1:0] pin_supply,
    output logic [2*PINS-1:0] pin_drive,
    // Wake request
    output logic wake_req
);
    logic [PINS-1:0] latch_q;
    logic [PINS-1:0] dir_q;
    logic [PINS-1:0] pullup_q;
    logic [PINS-1:0] wakeup_q;
    logic [PWR_SRC_W-1:0] pwr_src_q;
    logic [DATA_W-1:0] drive_q;
    logic [DATA_W-1:0] rdata_q;
    logic rvalid_q;
    logic wake_q;
    logic [PINS-1:0] pin_level;
    logic [PINS-1:0] pin_fall;
    logic [PINS-1:0] wake_arm;
    logic [PINS-1:0] port_read;
    logic [DATA_W-1:0] rd_mux;
    logic [PINS-1:0] impl;
    logic [PINS-1:0] wimpl;

    assign impl = IMPL_MASK[PINS-1:0];
    assign wimpl = WAKE_MASK[PINS-1:0] & impl;

    // Output latch
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            latch_q <= DATA_RST[PINS-1:0];
        end else if (wr_en && addr == REG_DATA) begin
            latch_q <= wdata[PINS-1:0] & impl;
        end
    end

    // Direction
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dir_q <= DIR_RST[PINS-1:0];
        end else if (wr_en && addr == REG_DIR) begin
            dir_q <= wdata[PINS-1:0] & impl;
        end
    end

    // Pull-up enables
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pullup_q <= PULLUP_RST[PINS-1:0];
        end else if (wr_en && addr == REG_PULLUP) begin
            pullup_q <= wdata[PINS-1:0] & impl;
        end
    end

    // Wake-up enables
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wakeup_q <= WAKEUP_RST[PINS-1:0];
        end else if (wr_en && addr == REG_WAKEUP) begin
            wakeup_q <= wdata[PINS-1:0] & wimpl;
        end
    end

    // Power source select
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pwr_src_q <= PWR_SRC_RST;
        end else if (wr_en && addr == REG_PWR_SRC) begin
            pwr_src_q <= wdata[PWR_SRC_W-1:0];
        end
    end

    // Drive level select
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            drive_q <= DRIVE_RST;
        end else if (wr_en && addr == REG_DRIVE) begin
            drive_q <= wdata;
        end
    end

    // Inputs pass a two-flop synchroniser; read level lags the pin two clocks
    pin_fall_detect #(
        .WIDTH(PINS)
    ) u_fall (
        .clock(clock),
        .rst(rst),
        .pin_raw(pin_in),
        .arm(wake_arm),
        .level(pin_level),
        .fall(pin_fall)
    );

    // Input pins show live level, outputs show the latch
    assign port_read = (dir_q & pin_level) | (~dir_q & latch_q);

    always_comb begin
        rd_mux = '0;
        case (addr)
            REG_DATA: rd_mux[PINS-1:0] = port_read & impl;
            REG_DIR: rd_mux[PINS-1:0] = dir_q;
            REG_PULLUP: rd_mux[PINS-1:0] = pullup_q;
            REG_WAKEUP: rd_mux[PINS-1:0] = wakeup_q;
            REG_PWR_SRC: rd_mux[PWR_SRC_W-1:0] = pwr_src_q;
            REG_DRIVE: rd_mux = drive_q;
            default: rd_mux = '0;
        endcase
    end

    // Registered read data, one cycle after the strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_en;
            if (rd_en) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;

    // Wake detection is armed only as GPIO input during sleep
    assign wake_arm = wakeup_q & dir_q & func_gpio & {PINS{core_asleep}};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= |pin_fall;
        end
    end

    assign wake_req = wake_q;

    // Map a written power code to the supply
    function automatic supply_t decode_supply(input logic [1:0] code);
        supply_t s;
        s = SUPPLY_MAIN;
        case (code)
            PSEL_MAIN_A: s = SUPPLY_MAIN;
            PSEL_MAIN_B: s = SUPPLY_MAIN;
            PSEL_AUX: s = SUPPLY_AUX;
            PSEL_REG3V3: s = SUPPLY_REG3V3;
            default: s = SUPPLY_MAIN;
        endcase
        return s;
    endfunction

    supply_t upper_supply;
    supply_t lower_supply;

    assign upper_supply = decode_supply(pwr_src_q[PWR_UPPER_LSB +: FIELD_W]);
    assign lower_supply = decode_supply(pwr_src_q[PWR_LOWER_LSB +: FIELD_W]);

    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            logic digital;
            logic upper_sel;
            logic lower_sel;

            assign digital = func_gpio[i] | DEBUG_MASK[i];
            assign upper_sel = UPPER_GROUP[i] & impl[i] & digital;
            assign lower_sel = LOWER_GROUP[i] & impl[i] & digital;

            // Push-pull drive of the latch when an output
            assign pin_out[i] = latch_q[i];
            assign pin_oe[i] = ~dir_q[i] & func_gpio[i] & impl[i];

            // Pull-up on only for a GPIO input or an open-drain pin, even if it drives
            assign pullup_on[i] = pullup_q[i] &
                ((func_gpio[i] & dir_q[i]) | func_open_drain[i]);

            always_comb begin
                if (upper_sel) begin
                    pin_supply[2*i +: 2] = upper_supply;
                end else if (lower_sel) begin
                    pin_supply[2*i +: 2] = lower_supply;
                end else begin
                    pin_supply[2*i +: 2] = SUPPLY_MAIN;
                end
            end

            // Field i/2 drives pins 2k and 2k+1
            assign pin_drive[2*i +: 2] = impl[i] ?
                drive_q[2*(i/2) +: 2] : DRIVE_MIN;
        end
    endgenerate
endmodule
`default_nettype wire

// ### io_bank_monitor.sv
// Purpose: Port checks for the I/O port bank
// Assumes: Default eight-pin build
// Notes: Bound to every bank instance
`timescale 1ns/100ps
`default_nettype none
module io_bank_monitor
    import gpio_bank_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Bus
    input wire logic [2:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    // Pins and controls
    input wire logic [7:0] func_gpio,
    input wire logic [7:0] func_open_drain,
    input wire logic core_asleep,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    input wire logic [15:0] pin_supply,
    input wire logic [15:0] pin_drive,
    input wire logic wake_req
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chk_oe_gpio: assert property ((pin_oe & ~func_gpio) == 8'h00)
        else $error("pin driven while not gpio");
    chk_latch_hold: assert property (!(wr_en && addr == REG_DATA) |=> $stable(pin_out))
        else $error("output latch moved");
    chk_pu_qual: assert property
        ((pullup_on & ~((func_gpio & ~pin_oe) | func_open_drain)) == 8'h00)
        else $error("pull-up on a driven pin");
    chk_wake_awake: assert property (!core_asleep [*4] |=> !wake_req)
        else $error("wake while awake");
    chk_wake_single: assert property (wake_req |=> !wake_req)
        else $error("wake pulse too long");
    chk_drive_map: assert property (wr_en && addr == REG_DRIVE |=>
        pin_drive[1:0] == $past(wdata[1:0]) && pin_drive[15:12] == {2{$past(wdata[7:6])}})
        else $error("drive field not applied");
    chk_supply_main: assert property (func_gpio == 8'h00 |-> pin_supply == 16'h0000)
        else $error("supply on non-gpio pin");
    chk_read_lat: assert property (rd_en |=> rvalid)
        else $error("read not answered");
    chk_unmapped: assert property (rd_en && addr > REG_DRIVE |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_dir_reset: assert property ($fell(rst) |-> pin_oe == 8'h00)
        else $error("pin driven after reset");
endmodule
bind gpio_port_bank io_bank_monitor u_mon (.clock, .rst, .addr, .wr_en, .rd_en, .wdata,
    .rdata, .rvalid, .func_gpio, .func_open_drain, .core_asleep, .pin_out, .pin_oe,
    .pullup_on, .pin_supply, .pin_drive, .wake_req);
`default_nettype wire

// ### pin_fall_detect.sv
// Purpose: Synchronise pin levels and flag qualified falling edges.
// Assumes: Pins are asynchronous to clock.
// Notes: First flop stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
module pin_fall_detect #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pins and qualifier
    input wire logic [WIDTH-1:0] pin_raw,
    input wire logic [WIDTH-1:0] arm,
    // Results
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] fall_q;

    // Reset high, so a pin already low gives one edge after reset if armed
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= '1;
            sync_q <= '1;
            prev_q <= '1;
        end else begin
            meta_q <= pin_raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // One pulse per edge, only while armed
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fall_q <= '0;
        end else begin
            fall_q <= prev_q & ~sync_q & arm;
        end
    end

    assign level = sync_q;
    assign fall = fall_q;
endmodule
`default_nettype wire
